/* verilog/mode_clock_cfg.svh */
// Register offsets, field positions, reset values of the mode and clock-output block
`ifndef MODE_CLOCK_CFG_SVH
`define MODE_CLOCK_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_BACKCHANNEL_MODE_SELECT   8'h04
`define OFS_PLL_REFERENCE_CONTROL     8'h05
`define OFS_CLOCK_OUTPUT_CONTROL_ZERO 8'h06
`define OFS_CLOCK_OUTPUT_CONTROL_ONE  8'h07

// ****************************************
// Reset values
// ****************************************
`define RST_BACKCHANNEL_MODE_SELECT   8'h00
`define RST_PLL_REFERENCE_CONTROL     8'h03
`define RST_CLOCK_OUTPUT_CONTROL_ZERO 8'h41
`define RST_CLOCK_OUTPUT_CONTROL_ONE  8'h28

// ****************************************
// Field positions
// ****************************************
`define BIT_RAW10_COMPAT_FLAG         2
`define BIT_RAW12_COMPAT_FLAG         1
`define BIT_COMPAT_AUTOLOAD_BLOCK     0
`define MSB_REF_INPUT_DIVIDER         6
`define LSB_REF_INPUT_DIVIDER         4
`define BIT_OSCILLATOR_RANGE_SELECT   3
`define MSB_HIGHSPEED_SOURCE_DIVIDER  7
`define LSB_HIGHSPEED_SOURCE_DIVIDER  5
`define MSB_RATIO_MULTIPLIER          4
`define LSB_RATIO_MULTIPLIER          0

// ****************************************
// Code limits and defaults
// ****************************************
`define REF_DIV_MAX_CODE              3'h3
`define HS_DIV_MAX_CODE               3'h4
`define RATIO_MULTIPLIER_DEFAULT      5'h01

`endif

/* verilog/mode_clock_pkg.sv */
// Types shared by the mode and clock-output block
package mode_clock_pkg;
    typedef logic [7:0] regByte_t;
    typedef logic [2:0] divCode_t;
    typedef enum {
        REF_FROM_INPUT,
        REF_FROM_OSCILLATOR
    } refSource_t;
endpackage

/* verilog/mn_ratio_divider.sv */
// M/N fractional tick divider for the sensor reference output
`timescale 1ns/100ps
`include "mode_clock_cfg.svh"

module mn_ratio_divider #(
    parameter int M_WIDTH = 5,
    parameter int N_WIDTH = 8
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Ratio and source
    input  wire logic [M_WIDTH-1:0] ratioMultiplier,
    input  wire logic [N_WIDTH-1:0] ratioDivisor,
    input  wire logic               srcTick,
    // Output
    output logic                    outTick
);
    logic [N_WIDTH-1:0] acc_r;
    logic [N_WIDTH:0]   sum;
    logic [N_WIDTH:0]   sumLessN;

    if (M_WIDTH > N_WIDTH) begin : g_width_check
        $error("mn_ratio_divider: M_WIDTH must not exceed N_WIDTH");
    end

    assign sum      = {1'b0, acc_r} + (N_WIDTH + 1)'(ratioMultiplier);
    assign sumLessN = sum - {1'b0, ratioDivisor};

    // ****************************************
    // Accumulate M per source tick, emit one tick per N
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_r   <= '0;
            outTick <= 1'b0;
        end else if (srcTick && ratioDivisor != '0) begin
            if (sum >= {1'b0, ratioDivisor}) begin
                // Ratio above one saturates at one tick per source tick
                acc_r   <= (sumLessN >= {1'b0, ratioDivisor}) ? '0 : sumLessN[N_WIDTH-1:0];
                outTick <= 1'b1;
            end else begin
                acc_r   <= sum[N_WIDTH-1:0];
                outTick <= 1'b0;
            end
        end else begin
            outTick <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_ratio_tick;
        @(posedge clk) disable iff (sys_rst)
        srcTick && ratioDivisor != '0 && sum >= {1'b0, ratioDivisor} |=> outTick;
    endproperty
    a_ratio_tick: assert property (p_ratio_tick) else $error("ratio tick missing");

    property p_n_zero_silent;
        @(posedge clk) disable iff (sys_rst)
        ratioDivisor == '0 |=> !outTick;
    endproperty
    a_n_zero_silent: assert property (p_n_zero_silent) else $error("N zero ticked");
endmodule

/* verilog/mode_and_clock_output_config.sv */
// Mode flags, reference selection and sensor clock-output configuration
`timescale 1ns/100ps
`include "mode_clock_cfg.svh"

// Overview of operation
// - After receive lock the channel loads the RAW10 compat flag in bit 2 unless blocked.
// - After receive lock the channel loads the RAW12 compat flag in bit 1 unless blocked.
// - With the autoload block bit 0 set, neither compat flag is loaded by the control channel.
// - Reference divider in bits 6:4 divides by 1, 2, 4 or 8 for codes 0 to 3; 4 to 7 reserved.
// - Oscillator select 0 asks for the 24.2 to 25.5 MHz range used at 2 Gbps.
// - Oscillator select 1 asks for the 48.4 to 51 MHz range used at 4 Gbps.
// - The oscillator reference is used in non-synchronous internal mode or with no system clock.
// - M/N source is the forward rate divided by 1, 2, 4, 8 or 16 for codes 0 to 4 in bits 7:5.
// - M sits in bits 4:0 and with N sets the ratio applied to the divided high-speed clock.
// - An M field of 0 is treated internally as 1.

module mode_and_clock_output_config
    import mode_clock_pkg::*;
#(
    parameter int M_WIDTH = 5,
    parameter int N_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Register access from the local and remote control path
    input  wire logic                     regWrEn,
    input  wire logic                     regRdEn,
    input  wire logic [7:0]               regAddr,
    input  wire mode_clock_pkg::regByte_t regWrData,
    output mode_clock_pkg::regByte_t      regRdData,
    // Control channel autoload
    input  wire logic                     rxLock,
    input  wire logic                     compatLoadValid,
    input  wire logic                     compatRaw10,
    input  wire logic                     compatRaw12,
    // Reference selection
    input  wire logic                     nonSyncInternalMode,
    input  wire logic                     extClkDetected,
    input  wire logic                     referenceInputTick,
    input  wire logic                     oscillatorTick,
    input  wire logic                     fwdRateTick,
    // Configuration and clock outputs
    output logic                          raw10CompatFlag,
    output logic                          raw12CompatFlag,
    output logic                          oscillatorRangeSelect,
    output logic                          internalRefTick,
    output logic                          sensorRefTick,
    output logic                          sensorRefOutput
);
    import mode_clock_pkg::*;

    if (M_WIDTH != 5 || N_WIDTH != 8) begin : g_width_check
        $error("mode_and_clock_output_config: field widths are fixed at 5 and 8");
    end

    // ****************************************
    // Registers
    // ****************************************
    regByte_t   modeSelect_r;
    regByte_t   refControl_r;
    regByte_t   clkOutZero_r;
    regByte_t   clkOutOne_r;
    logic       autoloadBlock;
    logic       autoloadFire;
    logic       swModeWrite;
    divCode_t   refDivCode;
    divCode_t   hsDivCode;
    logic [M_WIDTH-1:0] multiplierField;
    logic [M_WIDTH-1:0] multiplierEff;
    refSource_t refSource;
    logic [3:0] refCnt_r;
    logic [3:0] hsCnt_r;
    logic       hsTick_r;

    function automatic logic [3:0] divLimit(input divCode_t code);
        divLimit = 4'((5'h01 << code) - 5'h01);
    endfunction

    assign autoloadBlock   = modeSelect_r[`BIT_COMPAT_AUTOLOAD_BLOCK];
    assign swModeWrite     = regWrEn && regAddr == `OFS_BACKCHANNEL_MODE_SELECT;
    // Channel load wins over a write unless that write sets the block bit itself
    assign autoloadFire    = rxLock && compatLoadValid && !autoloadBlock
                             && !(swModeWrite && regWrData[`BIT_COMPAT_AUTOLOAD_BLOCK]);
    assign refDivCode      = refControl_r[`MSB_REF_INPUT_DIVIDER:`LSB_REF_INPUT_DIVIDER];
    assign hsDivCode       = clkOutZero_r[`MSB_HIGHSPEED_SOURCE_DIVIDER:
                                          `LSB_HIGHSPEED_SOURCE_DIVIDER];
    assign multiplierField = clkOutZero_r[`MSB_RATIO_MULTIPLIER:`LSB_RATIO_MULTIPLIER];
    assign multiplierEff   = (multiplierField == '0) ? `RATIO_MULTIPLIER_DEFAULT
                             : multiplierField;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modeSelect_r <= `RST_BACKCHANNEL_MODE_SELECT;
        end else begin
            if (swModeWrite) begin
                modeSelect_r <= regWrData;
            end
            if (autoloadFire) begin
                modeSelect_r[`BIT_RAW10_COMPAT_FLAG] <= compatRaw10;
                modeSelect_r[`BIT_RAW12_COMPAT_FLAG] <= compatRaw12;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refControl_r <= `RST_PLL_REFERENCE_CONTROL;
            clkOutZero_r <= `RST_CLOCK_OUTPUT_CONTROL_ZERO;
            clkOutOne_r  <= `RST_CLOCK_OUTPUT_CONTROL_ONE;
        end else if (regWrEn) begin
            if (regAddr == `OFS_PLL_REFERENCE_CONTROL) begin
                refControl_r <= regWrData;
            end
            if (regAddr == `OFS_CLOCK_OUTPUT_CONTROL_ZERO) begin
                clkOutZero_r <= regWrData;
            end
            if (regAddr == `OFS_CLOCK_OUTPUT_CONTROL_ONE) begin
                clkOutOne_r <= regWrData;
            end
        end
    end

    // Read data, unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `OFS_BACKCHANNEL_MODE_SELECT:   regRdData <= modeSelect_r;
                `OFS_PLL_REFERENCE_CONTROL:     regRdData <= refControl_r;
                `OFS_CLOCK_OUTPUT_CONTROL_ZERO: regRdData <= clkOutZero_r;
                `OFS_CLOCK_OUTPUT_CONTROL_ONE:  regRdData <= clkOutOne_r;
                default:                        regRdData <= 8'h00;
            endcase
        end
    end

    assign raw10CompatFlag       = modeSelect_r[`BIT_RAW10_COMPAT_FLAG];
    assign raw12CompatFlag       = modeSelect_r[`BIT_RAW12_COMPAT_FLAG];
    assign oscillatorRangeSelect =
        refControl_r[`BIT_OSCILLATOR_RANGE_SELECT];

    // ****************************************
    // Internal reference selection and divider
    // ****************************************
    assign refSource = (nonSyncInternalMode || !extClkDetected) ? REF_FROM_OSCILLATOR
                       : REF_FROM_INPUT;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            refCnt_r        <= 4'h0;
            internalRefTick <= 1'b0;
        end else begin
            case (refSource)
                REF_FROM_OSCILLATOR: begin
                    refCnt_r        <= 4'h0;
                    internalRefTick <= oscillatorTick;
                end
                REF_FROM_INPUT: begin
                    // Reserved codes stop the reference
                    if (refDivCode > `REF_DIV_MAX_CODE) begin
                        refCnt_r        <= 4'h0;
                        internalRefTick <= 1'b0;
                    end else if (referenceInputTick) begin
                        if (refCnt_r >= divLimit(refDivCode)) begin
                            refCnt_r        <= 4'h0;
                            internalRefTick <= 1'b1;
                        end else begin
                            refCnt_r        <= refCnt_r + 4'h1;
                            internalRefTick <= 1'b0;
                        end
                    end else begin
                        internalRefTick <= 1'b0;
                    end
                end
                default: begin
                    refCnt_r        <= 4'h0;
                    internalRefTick <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // High-speed source divider and M/N ratio
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hsCnt_r  <= 4'h0;
            hsTick_r <= 1'b0;
        end else if (hsDivCode > `HS_DIV_MAX_CODE) begin
            hsCnt_r  <= 4'h0;
            hsTick_r <= 1'b0;
        end else if (fwdRateTick) begin
            if (hsCnt_r >= divLimit(hsDivCode)) begin
                hsCnt_r  <= 4'h0;
                hsTick_r <= 1'b1;
            end else begin
                hsCnt_r  <= hsCnt_r + 4'h1;
                hsTick_r <= 1'b0;
            end
        end else begin
            hsTick_r <= 1'b0;
        end
    end

    mn_ratio_divider #(
        .M_WIDTH (M_WIDTH),
        .N_WIDTH (N_WIDTH)
    ) mn_ratio_divider_i (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .ratioMultiplier (multiplierEff),
        .ratioDivisor    (clkOutOne_r),
        .srcTick         (hsTick_r),
        .outTick         (sensorRefTick)
    );

    // Output clock toggles on each ratio tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sensorRefOutput <= 1'b0;
        end else if (sensorRefTick) begin
            sensorRefOutput <= !sensorRefOutput;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_raw10_load;
        @(posedge clk) disable iff (sys_rst)
        rxLock && compatLoadValid && !autoloadBlock && !swModeWrite
        |=> raw10CompatFlag == $past(compatRaw10);
    endproperty
    a_raw10_load: assert property (p_raw10_load) else $error("RAW10 flag not loaded");

    property p_raw12_load;
        @(posedge clk) disable iff (sys_rst)
        rxLock && compatLoadValid && !autoloadBlock && !swModeWrite
        |=> raw12CompatFlag == $past(compatRaw12);
    endproperty
    a_raw12_load: assert property (p_raw12_load) else $error("RAW12 flag not loaded");

    property p_block_holds;
        @(posedge clk) disable iff (sys_rst)
        autoloadBlock && !swModeWrite
        |=> $stable(raw10CompatFlag) && $stable(raw12CompatFlag);
    endproperty
    a_block_holds: assert property (p_block_holds) else $error("flags moved");

    property p_no_load_unlocked;
        @(posedge clk) disable iff (sys_rst)
        !rxLock && !swModeWrite |=> $stable(modeSelect_r);
    endproperty
    a_no_load_unlocked: assert property (p_no_load_unlocked)
        else $error("load without lock");

    property p_ref_reserved;
        @(posedge clk) disable iff (sys_rst)
        refSource == REF_FROM_INPUT && refDivCode > `REF_DIV_MAX_CODE |=> !internalRefTick;
    endproperty
    a_ref_reserved: assert property (p_ref_reserved) else $error("reserved ticked");

    property p_ref_div_two;
        @(posedge clk) disable iff (sys_rst)
        refSource == REF_FROM_INPUT && refDivCode == 3'h1 && referenceInputTick
        && refCnt_r == 4'h0 ##1 $stable(refControl_r) |-> !internalRefTick;
    endproperty
    a_ref_div_two: assert property (p_ref_div_two) else $error("divide by two");

    property p_osc_source;
        @(posedge clk) disable iff (sys_rst)
        refSource == REF_FROM_OSCILLATOR && oscillatorTick |=> internalRefTick;
    endproperty
    a_osc_source: assert property (p_osc_source) else $error("oscillator not used");

    property p_osc_range;
        @(posedge clk) disable iff (sys_rst)
        regWrEn && regAddr == `OFS_PLL_REFERENCE_CONTROL
        |=> oscillatorRangeSelect == $past(regWrData[`BIT_OSCILLATOR_RANGE_SELECT]);
    endproperty
    a_osc_range: assert property (p_osc_range) else $error("range select wrong");

    property p_hs_div_one;
        @(posedge clk) disable iff (sys_rst)
        hsDivCode == 3'h0 && fwdRateTick |=> hsTick_r;
    endproperty
    a_hs_div_one: assert property (p_hs_div_one) else $error("divide by one");

    property p_m_zero;
        @(posedge clk) disable iff (sys_rst)
        multiplierField == '0 |-> multiplierEff == M_WIDTH'(1);
    endproperty
    a_m_zero: assert property (p_m_zero) else $error("M zero not treated as one");

    c_autoload:  cover property (@(posedge clk) disable iff (sys_rst) autoloadFire);
    c_blocked:   cover property (@(posedge clk) disable iff (sys_rst)
                                 rxLock && compatLoadValid && autoloadBlock);
    c_ref_tick:  cover property (@(posedge clk) disable iff (sys_rst)
                                 refSource == REF_FROM_INPUT && internalRefTick);
    c_sensor:    cover property (@(posedge clk) disable iff (sys_rst) sensorRefTick);
endmodule

/* test/compat_link_model.sv */
// Companion deserializer model offering compat mode flags over the control channel
`timescale 1ns/100ps

module compat_link_model (
    // Clock
    input  wire logic clk,
    // Control channel toward the serializer
    output logic      rxLock,
    output logic      compatLoadValid,
    output logic      compatRaw10,
    output logic      compatRaw12
);
    initial begin
        rxLock = 1'b0;
        compatLoadValid = 1'b0;
        compatRaw10 = 1'b0;
        compatRaw12 = 1'b0;
    end

    // ****************************************
    // One flag offer, lines inverted once released
    // ****************************************
    task automatic offer(input logic lock, input logic r10, input logic r12);
        @(posedge clk);
        #1;
        rxLock = lock;
        compatLoadValid = 1'b1;
        compatRaw10 = r10;
        compatRaw12 = r12;
        @(posedge clk);
        #1;
        compatLoadValid = 1'b0;
        compatRaw10 = ~r10;
        compatRaw12 = ~r12;
    endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the mode and clock-output configuration block
`timescale 1ns/100ps
`include "mode_clock_cfg.svh"

module tb;
    import mode_clock_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic     clk, sysRst, regWrEn, regRdEn;
    logic     nonSyncInternalMode, extClkDetected;
    logic     referenceInputTick, oscillatorTick, fwdRateTick;
    logic     rxLock, compatLoadValid, compatRaw10, compatRaw12;
    logic     raw10CompatFlag, raw12CompatFlag, oscillatorRangeSelect;
    logic     internalRefTick, sensorRefTick, sensorRefOutput, outPrev;
    regByte_t regAddr, regWrData, regRdData;
    int       errorCnt = 0, nCompared = 0, refCnt, sensCnt, togCnt;

    compat_link_model compat_link_model_i (.clk(clk), .rxLock(rxLock),
        .compatLoadValid(compatLoadValid), .compatRaw10(compatRaw10),
        .compatRaw12(compatRaw12));

    mode_and_clock_output_config mode_and_clock_output_config_i (
        .clk(clk), .sys_rst(sysRst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .rxLock(rxLock), .compatLoadValid(compatLoadValid),
        .compatRaw10(compatRaw10), .compatRaw12(compatRaw12),
        .nonSyncInternalMode(nonSyncInternalMode), .extClkDetected(extClkDetected),
        .referenceInputTick(referenceInputTick), .oscillatorTick(oscillatorTick),
        .fwdRateTick(fwdRateTick), .raw10CompatFlag(raw10CompatFlag),
        .raw12CompatFlag(raw12CompatFlag), .oscillatorRangeSelect(oscillatorRangeSelect),
        .internalRefTick(internalRefTick), .sensorRefTick(sensorRefTick),
        .sensorRefOutput(sensorRefOutput));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Tick and toggle counters
    always @(posedge clk) begin
        if (internalRefTick === 1'b1) refCnt <= refCnt + 1;
        if (sensorRefTick === 1'b1) sensCnt <= sensCnt + 1;
        if (sensorRefOutput !== outPrev) togCnt <= togCnt + 1;
        outPrev <= sensorRefOutput;
    end

    // ****************************************
    // Compare and bus tasks
    // ****************************************
    task automatic chkByte(input string what, input regByte_t exp, input regByte_t got);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp, input logic got);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chkCount(input string what, input int exp, input int got);
        nCompared++;
        if (got != exp) begin
            errorCnt++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input regByte_t d);
        @(posedge clk);
        #1;
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(posedge clk);
        #1;
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input regByte_t exp);
        @(posedge clk);
        #1;
        regRdEn = 1'b1;
        regAddr = a;
        @(posedge clk);
        #1;
        regRdEn = 1'b0;
        @(posedge clk);
        #1;
        chkByte($sformatf("reg %h", a), exp, regRdData);
    endtask

    task automatic clearCounts;
        refCnt = 0;
        sensCnt = 0;
        togCnt = 0;
        outPrev = sensorRefOutput;
    endtask

    // Pulses one tick input n times: 0 reference, 1 oscillator, 2 forward rate
    task automatic pulses(input int which, input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            if (which == 0) referenceInputTick = 1'b1;
            else if (which == 1) oscillatorTick = 1'b1;
            else fwdRateTick = 1'b1;
            @(posedge clk);
            #1;
            referenceInputTick = 1'b0;
            oscillatorTick = 1'b0;
            fwdRateTick = 1'b0;
        end
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic closeOut;
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testReset;
        rd(`OFS_BACKCHANNEL_MODE_SELECT, `RST_BACKCHANNEL_MODE_SELECT);
        rd(`OFS_PLL_REFERENCE_CONTROL, `RST_PLL_REFERENCE_CONTROL);
        rd(`OFS_CLOCK_OUTPUT_CONTROL_ZERO, `RST_CLOCK_OUTPUT_CONTROL_ZERO);
        rd(`OFS_CLOCK_OUTPUT_CONTROL_ONE, `RST_CLOCK_OUTPUT_CONTROL_ONE);
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00);
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h00);
        chkBit("osc select", 1'b0, oscillatorRangeSelect);
        $display("test reset done");
    endtask

    task automatic testAutoload;
        compat_link_model_i.offer(1'b0, 1'b1, 1'b1);
        chkBit("raw10 flag", 1'b0, raw10CompatFlag);
        compat_link_model_i.offer(1'b1, 1'b1, 1'b0);
        chkBit("raw10 flag", 1'b1, raw10CompatFlag);
        chkBit("raw12 flag", 1'b0, raw12CompatFlag);
        compat_link_model_i.offer(1'b1, 1'b0, 1'b1);
        chkBit("raw10 flag", 1'b0, raw10CompatFlag);
        chkBit("raw12 flag", 1'b1, raw12CompatFlag);
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h02);
        wr(`OFS_BACKCHANNEL_MODE_SELECT, 8'h05);
        compat_link_model_i.offer(1'b1, 1'b0, 1'b1);
        chkBit("raw10 flag", 1'b1, raw10CompatFlag);
        chkBit("raw12 flag", 1'b0, raw12CompatFlag);
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h05);
        wr(`OFS_BACKCHANNEL_MODE_SELECT, 8'h00);
        compat_link_model_i.offer(1'b1, 1'b1, 1'b1);
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h06);
        // Same-cycle write that sets the block refuses the load
        fork
            compat_link_model_i.offer(1'b1, 1'b1, 1'b1);
            wr(`OFS_BACKCHANNEL_MODE_SELECT, 8'h01);
        join
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h01);
        wr(`OFS_BACKCHANNEL_MODE_SELECT, 8'h00);
        // Same-cycle write without the block keeps the loaded flag bits
        fork
            compat_link_model_i.offer(1'b1, 1'b0, 1'b1);
            wr(`OFS_BACKCHANNEL_MODE_SELECT, 8'h00);
        join
        rd(`OFS_BACKCHANNEL_MODE_SELECT, 8'h02);
        $display("test autoload done");
    endtask

    task automatic testRefDivider;
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_PLL_REFERENCE_CONTROL, 8'h43);
            wr(`OFS_PLL_REFERENCE_CONTROL, {1'b0, c[2:0], 4'h3});
            clearCounts;
            pulses(0, 16);
            chkCount("ref ticks", 16 >> c, refCnt);
        end
        wr(`OFS_PLL_REFERENCE_CONTROL, 8'h43);
        clearCounts;
        pulses(0, 16);
        chkCount("ref ticks reserved", 0, refCnt);
        $display("test ref divider done");
    endtask

    task automatic testOscillator;
        wr(`OFS_PLL_REFERENCE_CONTROL, 8'h0b);
        chkBit("osc select", 1'b1, oscillatorRangeSelect);
        rd(`OFS_PLL_REFERENCE_CONTROL, 8'h0b);
        wr(`OFS_PLL_REFERENCE_CONTROL, 8'h03);
        chkBit("osc select", 1'b0, oscillatorRangeSelect);
        clearCounts;
        pulses(1, 4);
        chkCount("osc ticks with clock", 0, refCnt);
        extClkDetected = 1'b0;
        clearCounts;
        pulses(1, 5);
        pulses(0, 3);
        chkCount("osc ticks no clock", 5, refCnt);
        extClkDetected = 1'b1;
        nonSyncInternalMode = 1'b1;
        clearCounts;
        pulses(1, 3);
        chkCount("osc ticks non-sync", 3, refCnt);
        nonSyncInternalMode = 1'b0;
        $display("test oscillator done");
    endtask

    task automatic hsRun(input logic [2:0] c, input logic [4:0] m, input regByte_t n,
                         input int exp);
        wr(`OFS_CLOCK_OUTPUT_CONTROL_ONE, n);
        wr(`OFS_CLOCK_OUTPUT_CONTROL_ZERO, {3'h7, m});
        wr(`OFS_CLOCK_OUTPUT_CONTROL_ZERO, {c, m});
        clearCounts;
        pulses(2, 32);
        chkCount("sensor ticks", exp, sensCnt);
        chkCount("output toggles", exp, togCnt);
    endtask

    task automatic testClockOut;
        for (int c = 0; c < 5; c++) begin
            hsRun(c[2:0], 5'h01, 8'h01, 32 >> c);
        end
        hsRun(3'h0, 5'h00, 8'h01, 32);
        hsRun(3'h0, 5'h01, 8'h02, 16);
        hsRun(3'h0, 5'h03, 8'h04, 24);
        hsRun(3'h1, 5'h03, 8'h04, 12);
        $display("test clock output done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        sysRst = 1'b1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        nonSyncInternalMode = 1'b0;
        extClkDetected = 1'b1;
        referenceInputTick = 1'b0;
        oscillatorTick = 1'b0;
        fwdRateTick = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        sysRst = 1'b0;
        testReset;
        testAutoload;
        testRefDivider;
        testOscillator;
        testClockOut;
        closeOut;
    end

    initial begin
        #2000000;
        errorCnt++;
        closeOut;
    end
endmodule
